// >>> test/cmd_port_host.sv
/*
  Host model driving the serial command port.
  Assumes mclk from the bench; link clock period is 8 mclk.
*/
module cmd_port_host (
  input wire logic mclk,
  input wire logic doutOut,
  input wire logic doutOe_n,
  output logic csPin_n,
  output logic dclkPin,
  output logic dinPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastBit = 1'b0;
  initial begin
    csPin_n = 1'b1;
    dclkPin = 1'b0;
    dinPin = 1'b0;
  end

  // Frame of n rising edges, last 8 carry tx, MSB first
  task automatic frame(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
    int k;
    rx = 8'h00;
    @(posedge mclk);
    csPin_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      k = i - (n - 8);
      @(posedge mclk);
      dclkPin <= 1'b0;
      dinPin <= (k >= 0) ? tx[7 - k] : 1'b1;
      repeat (4) @(posedge mclk);
      dclkPin <= 1'b1;
      lastBit = doutOe_n ? ~lastBit : doutOut;
      if (k >= 0) rx[7 - k] = lastBit;
      repeat (3) @(posedge mclk);
    end
    @(posedge mclk);
    dclkPin <= 1'b0;
    repeat (4) @(posedge mclk);
    csPin_n <= 1'b1;
    dinPin <= ~dinPin;
    repeat (10) @(posedge mclk);
  endtask : frame

  task automatic write_reg(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] v;
    frame({c[7:1], 1'b0}, 8, v);
    frame(d, 8, v);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] c, output logic [7:0] d);
    logic [7:0] v;
    frame({c[7:1], 1'b1}, 8, v);
    frame(8'h00, 8, d);
  endtask : read_reg
endmodule : cmd_port_host

// >>> test/cmd_regs_monitor.sv
/*
  Port checker for the global command register group.
  Assumes a bind onto the top module, one clock domain on mclk.
*/
module cmd_regs_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic csPin_n,
  input wire logic doutOe_n,
  input wire logic rstPin_n,
  input wire logic pcmClkPresent,
  input wire logic clockSyncStandbyBit,
  input wire logic [1:0] chanInShutdown,
  input wire logic irqRequest,
  input wire logic intOut,
  input wire logic intOe_n,
  input wire slic_cmd_pkg::pcm_cfg_t pcmCfg,
  input wire logic wideBandwidthSel,
  input wire logic [1:0] chanCmdEnable,
  input wire logic [1:0] chanToDisconnect,
  input wire logic chanToShutdown,
  input wire logic masterClkSlow,
  input wire logic supervisionRun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  rst_defaults_a: assert property ($fell(sys_rst) |->
    chanCmdEnable == 2'b11 && !wideBandwidthSel &&
    pcmCfg.txSlotNum[1] == 7'h01 && pcmCfg.pcmClockRateSel == 4'hA)
    else $error("defaults wrong after reset");
  pin_reset_a: assert property (!rstPin_n [*5] |->
    chanToShutdown && chanCmdEnable == 2'b11 && pcmCfg.clkSlot == 7'h00)
    else $error("reset pin did not restore defaults");
  disc_subset_a: assert property (|chanToDisconnect |->
    (chanToDisconnect & ~$past(chanCmdEnable)) == 2'b00)
    else $error("disabled channel disconnected");
  disc_shutdown_a: assert property (|chanToDisconnect |->
    (chanToDisconnect & $past(chanInShutdown)) == 2'b00)
    else $error("shut down channel disconnected");
  disc_pulse_a: assert property (|chanToDisconnect |=>
    chanToDisconnect == 2'b00)
    else $error("disconnect pulse too long");
  irq_pin_a: assert property ($stable(irqRequest) |->
    (!intOe_n && intOut == !irqRequest) ||
    (!intOut && intOe_n == !irqRequest))
    else $error("interrupt pin levels wrong");
  gci_signal_a: assert property (!pcmCfg.active |->
    !pcmCfg.highwaySignalingEn)
    else $error("signaling on outside pcm mode");
  rate_valid_a: assert property ($stable(pcmCfg.pcmClockRateSel) |->
    pcmCfg.pcmClockRateValid == (pcmCfg.pcmClockRateSel != 4'h7 &&
    pcmCfg.pcmClockRateSel < 4'hB))
    else $error("rate valid flag wrong");
  slow_clk_a: assert property (!pcmClkPresent [*5] |-> masterClkSlow)
    else $error("master clock not slowed");
  standby_a: assert property (!clockSyncStandbyBit [*2] |->
    supervisionRun)
    else $error("supervision stopped");
  dout_idle_a: assert property (csPin_n [*4] |-> doutOe_n)
    else $error("dout driven while deselected");
endmodule : cmd_regs_monitor

// >>> test/tb_top.sv
/*
  Self-checking bench for the global command register group.
  Assumes the host model and the port checker are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic rstPin_n = 1'b1;
  logic gciModePin = 1'b0;
  logic pcmClkPresent = 1'b1;
  logic clockSyncStandbyBit = 1'b0;
  logic [1:0] chanInShutdown = 2'b00;
  logic irqRequest = 1'b0;
  logic csPin_n, dclkPin, dinPin, doutOut, doutOe_n, intOut, intOe_n;
  logic wideBandwidthSel, chanToShutdown, masterClkSlow, supervisionRun;
  logic [1:0] chanCmdEnable, chanToDisconnect;
  logic [1:0] seenDisc = 2'b00;
  logic seenShut = 1'b0;
  slic_cmd_pkg::pcm_cfg_t pcmCfg;
  int n_mismatch = 0;
  int check_count = 0;

  always #10 mclk = ~mclk;

  slic_codec_global_command_regs slic_codec_global_command_regs_inst (.*);
  cmd_port_host cmd_port_host_inst (.*);

  // Latch pulses seen during a frame
  always @(posedge mclk) begin
    if (|chanToDisconnect) seenDisc <= chanToDisconnect;
    if (chanToShutdown) seenShut <= 1'b1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    cmd_port_host_inst.write_reg(c, d);
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] v;
    cmd_port_host_inst.read_reg(c, v);
    chk(v, exp);
  endtask : rd

  task automatic fr(input logic [7:0] c, input int n);
    logic [7:0] v;
    cmd_port_host_inst.frame(c, n, v);
  endtask : fr

  task automatic t_defaults();
    rd(8'h41, 8'h00);
    rd(8'h43, 8'h00);
    rd(8'h45, 8'h00);
    rd(8'h47, 8'h8A);
    rd(8'h4B, 8'h03);
    chk({1'b0, pcmCfg.txSlotNum[1]}, 8'h01);
    chk({1'b0, pcmCfg.rxSlotNum[1]}, 8'h01);
    chk({6'h0, intOut, intOe_n}, 8'h01);
  endtask : t_defaults

  task automatic t_regs();
    wr(8'h44, 8'h7F);
    chk({1'b0, pcmCfg.clkSlot}, 8'h7F);
    rd(8'h45, 8'h7F);
    wr(8'h44, 8'h2B);
    chk({7'h0, pcmCfg.clkSlot.txEdgeSel}, 8'h00);
    chk({5'h0, pcmCfg.clkSlot.rxBitOffset}, 8'h05);
    chk({5'h0, pcmCfg.clkSlot.txBitOffset}, 8'h03);
    for (int c = 0; c < 16; c++) begin
      wr(8'h46, 8'h20 | 8'(c));
      chk({4'h0, pcmCfg.pcmClockRateSel}, 8'(c));
      chk({7'h0, pcmCfg.pcmClockRateValid}, 8'(c != 7 && c < 11));
      chk({7'h0, pcmCfg.highwaySignalingEn}, 8'h01);
    end
    rd(8'h47, 8'h2F);
  endtask : t_regs

  task automatic t_enable();
    wr(8'h4A, 8'h01);
    wr(8'h40, 8'h05);
    wr(8'h42, 8'h11);
    wr(8'h4A, 8'h02);
    wr(8'h40, 8'h09);
    chk({1'b0, pcmCfg.txSlotNum[0]}, 8'h05);
    chk({1'b0, pcmCfg.txSlotNum[1]}, 8'h09);
    chk({1'b0, pcmCfg.rxSlotNum[0]}, 8'h11);
    chk({1'b0, pcmCfg.rxSlotNum[1]}, 8'h01);
    wr(8'h4A, 8'h20);
    chk({5'h0, wideBandwidthSel, chanCmdEnable}, 8'h04);
    wr(8'h40, 8'h33);
    wr(8'h44, 8'h12);
    chk({1'b0, pcmCfg.txSlotNum[0]}, 8'h05);
    chk({1'b0, pcmCfg.clkSlot}, 8'h12);
    rd(8'h41, 8'h00);
    seenDisc <= 2'b00;
    fr(8'h02, 8);
    chk({6'h0, seenDisc}, 8'h00);
    wr(8'h4A, 8'h03);
  endtask : t_enable

  task automatic t_soft();
    slic_cmd_pkg::pcm_cfg_t snap;
    chanInShutdown <= 2'b10;
    seenDisc <= 2'b00;
    fr(8'h02, 8);
    chk({6'h0, seenDisc}, 8'h01);
    chk({1'b0, pcmCfg.txSlotNum[1]}, 8'h09);
    chk({1'b0, pcmCfg.clkSlot}, 8'h12);
    chanInShutdown <= 2'b00;
    seenDisc <= 2'b00;
    fr(8'h02, 8);
    chk({6'h0, seenDisc}, 8'h03);
    snap = pcmCfg;
    seenShut <= 1'b0;
    fr(8'h06, 8);
    chk({7'h0, pcmCfg === snap}, 8'h01);
    chk({5'h0, seenShut, chanCmdEnable}, 8'h03);
  endtask : t_soft

  task automatic t_hard();
    for (int k = 0; k < 5; k++) begin
      wr(8'h44, 8'h7F);
      wr(8'h4A, 8'h20);
      seenShut <= 1'b0;
      if (k == 0) fr(8'h04, 5);
      if (k == 1) fr(8'h04, 8);
      if (k == 2) fr(8'h04, 12);
      if (k == 3) fr(8'h00, 16);
      if (k == 4) begin
        rstPin_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rstPin_n <= 1'b1;
        repeat (6) @(posedge mclk);
      end
      chk({7'h0, seenShut}, {7'h0, k != 0});
      chk({1'b0, pcmCfg.clkSlot}, k ? 8'h00 : 8'h7F);
      chk({5'h0, wideBandwidthSel, chanCmdEnable}, k ? 8'h03 : 8'h04);
      chk({1'b0, pcmCfg.txSlotNum[1]}, k ? 8'h01 : 8'h09);
    end
  endtask : t_hard

  task automatic t_pins();
    wr(8'h46, 8'h2A);
    gciModePin <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({6'h0, pcmCfg.active, pcmCfg.highwaySignalingEn}, 8'h00);
    gciModePin <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({6'h0, pcmCfg.active, pcmCfg.highwaySignalingEn}, 8'h03);
    for (int s = 0; s < 2; s++) begin
      wr(8'h46, {s[0], 7'h0A});
      for (int r = 0; r < 2; r++) begin
        irqRequest <= r[0];
        repeat (4) @(posedge mclk);
        chk({6'h0, intOut, intOe_n}, r ? 8'h00 : (s ? 8'h01 : 8'h02));
      end
    end
    pcmClkPresent <= 1'b0;
    clockSyncStandbyBit <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({6'h0, masterClkSlow, supervisionRun}, 8'h02);
    clockSyncStandbyBit <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({6'h0, masterClkSlow, supervisionRun}, 8'h03);
    pcmClkPresent <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({6'h0, masterClkSlow, supervisionRun}, 8'h01);
  endtask : t_pins

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_defaults();
    t_regs();
    t_enable();
    t_soft();
    t_hard();
    t_pins();
    test_done();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    $display("[ERR] %0t timeout", $time);
    n_mismatch++;
    test_done();
  end
endmodule : tb_top

bind slic_codec_global_command_regs cmd_regs_monitor cmd_regs_monitor_inst (.*);

// >>> verilog/mpi_shifter.sv
/*
  Serial command port front end: synchronises the port pins, collects
  framed bytes, classifies each frame and shifts read data out.
  Assumes the port clock is much slower than mclk.
*/
module mpi_shifter (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic csPin_n,
  input wire logic dclkPin,
  input wire logic dinPin,
  input wire logic [7:0] txByte,
  input wire logic txLoad,
  output logic [7:0] rxByte,
  output logic frameDone,
  output slic_cmd_pkg::frame_kind_t frameKind,
  output logic doutOut,
  output logic doutOe_n
);

  typedef struct packed {
    logic csS1;
    logic csS2;
    logic csPrev;
    logic ckS1;
    logic ckS2;
    logic ckPrev;
    logic dS1;
    logic dS2;
    logic [7:0] shiftIn;
    logic [slic_cmd_pkg::EDGE_CNT_W-1:0] edgeCnt;
    logic [7:0] shiftOut;
    logic driving;
    logic [7:0] rxByte;
    logic frameDone;
    slic_cmd_pkg::frame_kind_t frameKind;
  } shift_state_t;

  localparam shift_state_t SHIFT_RST = '{csS1: 1'b1, csS2: 1'b1,
    csPrev: 1'b1, frameKind: slic_cmd_pkg::FR_SHORT, default: '0};

  shift_state_t s;
  shift_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.frameDone = 1'b0;
    next_s.csS1 = csPin_n;
    next_s.csS2 = s.csS1;
    next_s.ckS1 = dclkPin;
    next_s.ckS2 = s.ckS1;
    next_s.dS1 = dinPin;
    next_s.dS2 = s.dS1;
    next_s.csPrev = s.csS2;
    next_s.ckPrev = s.ckS2;
    if (s.csPrev && !s.csS2) begin
      next_s.edgeCnt = '0;
      next_s.shiftOut = txByte;
      next_s.driving = txLoad;
    end else if (!s.csS2) begin
      if (!s.ckPrev && s.ckS2) begin
        next_s.shiftIn = {s.shiftIn[6:0], s.dS2};
        if (s.edgeCnt < slic_cmd_pkg::EDGE_CNT_W'(
            slic_cmd_pkg::HW_RESET_EDGES)) begin
          next_s.edgeCnt = s.edgeCnt + 1'b1;
        end
      end
      if (s.ckPrev && !s.ckS2) begin
        next_s.shiftOut = {s.shiftOut[6:0], 1'b0};
      end
    end else if (!s.csPrev && s.csS2) begin
      next_s.driving = 1'b0;
      next_s.frameDone = 1'b1;
      next_s.rxByte = s.shiftIn;
      if (s.edgeCnt >= slic_cmd_pkg::EDGE_CNT_W'(
          slic_cmd_pkg::HW_RESET_EDGES)) begin
        next_s.frameKind = slic_cmd_pkg::FR_LONG;
      end else if (s.edgeCnt >= slic_cmd_pkg::EDGE_CNT_W'(
          slic_cmd_pkg::BYTE_BITS)) begin
        next_s.frameKind = slic_cmd_pkg::FR_BYTE;
      end else begin
        next_s.frameKind = slic_cmd_pkg::FR_SHORT;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s <= SHIFT_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rxByte = s.rxByte;
  assign frameDone = s.frameDone;
  assign frameKind = s.frameKind;
  assign doutOut = s.shiftOut[7];
  assign doutOe_n = ~(s.driving & ~s.csS2);

endmodule : mpi_shifter

// >>> verilog/slic_cmd_pkg.sv
/*
  Constants, field layouts and carrier types for the global command
  register group of a dual-channel line interface device.
  Assumes a single 50 MHz system clock and a serial command port.
*/
// Summary of operation
// - Soft reset hits enabled channels only.
// - Soft reset: Disconnect unless already Shutdown.
// - Hard reset command equals reset pin.
// - Global commands ignore channel enables.
// - Per-channel 7-bit transmit slot, defaults 0/1.
// - Per-channel 7-bit receive slot, same defaults.
// - PCM settings ignored in GCI mode.
// - Edge bit picks transmit clock edge.
// - Three-bit receive and transmit clock slots.
// - Interrupt pin push-pull or open-drain.
// - Highway signaling enable bit.
// - Four-bit PCM clock rate select.
// - Slow clock and standby without PCM clock.
// - Wideband bit selects codec bandwidth.
// - Channel enables gate channel-scoped commands.
// - Channel enable register resets to 03h.
// - Hardware reset restores every default.
// - Read data drains before next command.
package slic_cmd_pkg;

  localparam int BYTE_BITS = 8;
  localparam int HW_RESET_EDGES = 16;
  localparam int EDGE_CNT_W = 5;
  localparam int NUM_CHAN = 2;
  localparam int SLOT_W = 7;
  localparam int CSLOT_W = 3;
  localparam int PCM_CLOCK_RATE_SEL_W = 4;

  // Command codes, write form
  localparam logic [7:0] CMD_SOFT_RESET = 8'h02;
  localparam logic [7:0] CMD_HARD_RESET = 8'h04;
  localparam logic [7:0] CMD_NOP = 8'h06;
  localparam logic [7:0] CMD_TX_SLOT = 8'h40;
  localparam logic [7:0] CMD_RX_SLOT = 8'h42;
  localparam logic [7:0] CMD_CLK_SLOT = 8'h44;
  localparam logic [7:0] CMD_DEV_CFG = 8'h46;
  localparam logic [7:0] CMD_CHAN_EN = 8'h4A;
  localparam int RW_BIT = 0;

  // Field positions
  localparam int EDGE_BIT = 6;
  localparam int RCS_LSB = 3;
  localparam int TCS_LSB = 0;
  localparam int IRQ_OUTPUT_STYLE_BIT = 7;
  localparam int HIGHWAY_SIGNALING_EN_BIT = 5;
  localparam int PCM_CLOCK_RATE_SEL_LSB = 0;
  localparam int WIDE_BANDWIDTH_SEL_BIT = 5;
  localparam int EC1_BIT = 0;
  localparam int EC2_BIT = 1;

  // Reset values
  localparam logic [6:0] SLOT_RST_CH1 = 7'h00;
  localparam logic [6:0] SLOT_RST_CH2 = 7'h01;
  localparam logic [7:0] CLK_SLOT_RST = 8'h00;
  localparam logic [7:0] DEV_CFG_RST = 8'h8A;
  localparam logic [7:0] CHAN_EN_RST = 8'h03;

  // Reserved clock select codes
  localparam logic [3:0] PCM_CLOCK_RATE_SEL_RSV_A = 4'h7;
  localparam logic [3:0] PCM_CLOCK_RATE_SEL_RSV_MIN = 4'hB;

  typedef enum logic [1:0] {FR_SHORT, FR_BYTE, FR_LONG} frame_kind_t;
  typedef enum logic [1:0] {ST_CMD, ST_WDATA, ST_RDATA} cmd_state_t;

  typedef struct packed {
    logic txEdgeSel;
    logic [CSLOT_W-1:0] rxBitOffset;
    logic [CSLOT_W-1:0] txBitOffset;
  } clk_slot_t;

  typedef struct packed {
    logic irqOutputStyle;
    logic highwaySignalingEn;
    logic [PCM_CLOCK_RATE_SEL_W-1:0] pcmClockRateSel;
  } dev_cfg_t;

  typedef struct packed {
    logic wideBandwidthSel;
    logic chan2CmdEnable;
    logic chan1CmdEnable;
  } chan_en_t;

  typedef struct packed {
    logic active;
    logic [NUM_CHAN-1:0][SLOT_W-1:0] txSlotNum;
    logic [NUM_CHAN-1:0][SLOT_W-1:0] rxSlotNum;
    clk_slot_t clkSlot;
    logic highwaySignalingEn;
    logic [PCM_CLOCK_RATE_SEL_W-1:0] pcmClockRateSel;
    logic pcmClockRateValid;
  } pcm_cfg_t;

endpackage : slic_cmd_pkg

// >>> verilog/slic_codec_global_command_regs.sv
/*
  Global command register group: decodes reset, no-operation, time
  slot, clock slot, device configuration and channel enable commands
  arriving on the serial command port, and drives the resulting
  settings to the codec, PCM highway and interrupt pin logic.
  Assumes channel state and PCM clock detection live elsewhere on mclk.
*/
module slic_codec_global_command_regs #(
  parameter int NUM_CHAN = slic_cmd_pkg::NUM_CHAN
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic csPin_n,
  input wire logic dclkPin,
  input wire logic dinPin,
  output logic doutOut,
  output logic doutOe_n,
  input wire logic rstPin_n,
  input wire logic gciModePin,
  input wire logic pcmClkPresent,
  input wire logic clockSyncStandbyBit,
  input wire logic [1:0] chanInShutdown,
  input wire logic irqRequest,
  output logic intOut,
  output logic intOe_n,
  output slic_cmd_pkg::pcm_cfg_t pcmCfg,
  output logic wideBandwidthSel,
  output logic [1:0] chanCmdEnable,
  output logic [1:0] chanToDisconnect,
  output logic chanToShutdown,
  output logic masterClkSlow,
  output logic supervisionRun
);

  typedef struct packed {
    logic rstS1;
    logic rstS2;
    logic gciS1;
    logic gciS2;
    logic clkS1;
    logic clkS2;
    slic_cmd_pkg::cmd_state_t fsm;
    logic [7:0] cmd;
    logic [1:0][6:0] txSlot;
    logic [1:0][6:0] rxSlot;
    slic_cmd_pkg::clk_slot_t clkSlot;
    slic_cmd_pkg::dev_cfg_t devCfg;
    slic_cmd_pkg::chan_en_t chanEn;
    logic [7:0] readByte;
    logic readPending;
    logic [1:0] disconnectPulse;
    logic shutdownPulse;
  } regs_state_t;

  regs_state_t s;
  regs_state_t next_s;
  logic [7:0] rxByte;
  logic frameDone;
  slic_cmd_pkg::frame_kind_t frameKind;

  // Ports and registers are sized for two channels
  if (NUM_CHAN != slic_cmd_pkg::NUM_CHAN) begin : g_chan_check
    $error("channel count must be two");
  end

  // Register defaults, sync stages left as they are
  function automatic regs_state_t hardDefaults(input regs_state_t v);
    regs_state_t r;
    r = v;
    r.fsm = slic_cmd_pkg::ST_CMD;
    r.cmd = '0;
    r.txSlot[0] = slic_cmd_pkg::SLOT_RST_CH1;
    r.txSlot[1] = slic_cmd_pkg::SLOT_RST_CH2;
    r.rxSlot[0] = slic_cmd_pkg::SLOT_RST_CH1;
    r.rxSlot[1] = slic_cmd_pkg::SLOT_RST_CH2;
    r.clkSlot = unpackClkSlot(slic_cmd_pkg::CLK_SLOT_RST);
    r.devCfg = unpackDevCfg(slic_cmd_pkg::DEV_CFG_RST);
    r.chanEn = unpackChanEn(slic_cmd_pkg::CHAN_EN_RST);
    r.readByte = '0;
    r.readPending = 1'b0;
    r.disconnectPulse = '0;
    return r;
  endfunction : hardDefaults

  function automatic slic_cmd_pkg::clk_slot_t unpackClkSlot(
      input logic [7:0] b);
    slic_cmd_pkg::clk_slot_t c;
    c.txEdgeSel = b[slic_cmd_pkg::EDGE_BIT];
    c.rxBitOffset = b[slic_cmd_pkg::RCS_LSB +: slic_cmd_pkg::CSLOT_W];
    c.txBitOffset = b[slic_cmd_pkg::TCS_LSB +: slic_cmd_pkg::CSLOT_W];
    return c;
  endfunction : unpackClkSlot

  function automatic slic_cmd_pkg::dev_cfg_t unpackDevCfg(
      input logic [7:0] b);
    slic_cmd_pkg::dev_cfg_t d;
    d.irqOutputStyle = b[slic_cmd_pkg::IRQ_OUTPUT_STYLE_BIT];
    d.highwaySignalingEn = b[slic_cmd_pkg::HIGHWAY_SIGNALING_EN_BIT];
    d.pcmClockRateSel = b[slic_cmd_pkg::PCM_CLOCK_RATE_SEL_LSB +: slic_cmd_pkg::PCM_CLOCK_RATE_SEL_W];
    return d;
  endfunction : unpackDevCfg

  function automatic slic_cmd_pkg::chan_en_t unpackChanEn(
      input logic [7:0] b);
    slic_cmd_pkg::chan_en_t e;
    e.wideBandwidthSel = b[slic_cmd_pkg::WIDE_BANDWIDTH_SEL_BIT];
    e.chan2CmdEnable = b[slic_cmd_pkg::EC2_BIT];
    e.chan1CmdEnable = b[slic_cmd_pkg::EC1_BIT];
    return e;
  endfunction : unpackChanEn

  // Lowest enabled channel answers channel-scoped reads
  function automatic logic [7:0] slotRead(input logic [1:0][6:0] slot,
      input logic [1:0] en);
    logic [7:0] b;
    b = '0;
    if (en[0]) begin
      b = {1'b0, slot[0]};
    end else if (en[1]) begin
      b = {1'b0, slot[1]};
    end
    return b;
  endfunction : slotRead

  // Read value of a register, reserved bits as zero
  function automatic logic [7:0] readValue(input regs_state_t v,
      input logic [7:0] code);
    logic [7:0] b;
    logic [1:0] en;
    b = '0;
    en = {v.chanEn.chan2CmdEnable, v.chanEn.chan1CmdEnable};
    case (code & ~8'h01)
      slic_cmd_pkg::CMD_TX_SLOT: b = slotRead(v.txSlot, en);
      slic_cmd_pkg::CMD_RX_SLOT: b = slotRead(v.rxSlot, en);
      slic_cmd_pkg::CMD_CLK_SLOT: begin
        b[slic_cmd_pkg::EDGE_BIT] = v.clkSlot.txEdgeSel;
        b[slic_cmd_pkg::RCS_LSB +: slic_cmd_pkg::CSLOT_W] =
          v.clkSlot.rxBitOffset;
        b[slic_cmd_pkg::TCS_LSB +: slic_cmd_pkg::CSLOT_W] =
          v.clkSlot.txBitOffset;
      end
      slic_cmd_pkg::CMD_DEV_CFG: begin
        b[slic_cmd_pkg::IRQ_OUTPUT_STYLE_BIT] = v.devCfg.irqOutputStyle;
        b[slic_cmd_pkg::HIGHWAY_SIGNALING_EN_BIT] = v.devCfg.highwaySignalingEn;
        b[slic_cmd_pkg::PCM_CLOCK_RATE_SEL_LSB +: slic_cmd_pkg::PCM_CLOCK_RATE_SEL_W] =
          v.devCfg.pcmClockRateSel;
      end
      slic_cmd_pkg::CMD_CHAN_EN: begin
        b[slic_cmd_pkg::WIDE_BANDWIDTH_SEL_BIT] = v.chanEn.wideBandwidthSel;
        b[slic_cmd_pkg::EC2_BIT] = v.chanEn.chan2CmdEnable;
        b[slic_cmd_pkg::EC1_BIT] = v.chanEn.chan1CmdEnable;
      end
      default: b = '0;
    endcase
    return b;
  endfunction : readValue

  // Opcode groups that expect one data byte
  function automatic logic hasData(input logic [7:0] code);
    logic r;
    r = 1'b0;
    case (code & ~8'h01)
      slic_cmd_pkg::CMD_TX_SLOT,
      slic_cmd_pkg::CMD_RX_SLOT,
      slic_cmd_pkg::CMD_CLK_SLOT,
      slic_cmd_pkg::CMD_DEV_CFG,
      slic_cmd_pkg::CMD_CHAN_EN: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : hasData

  mpi_shifter u_shifter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .csPin_n(csPin_n),
    .dclkPin(dclkPin),
    .dinPin(dinPin),
    .txByte(s.readByte),
    .txLoad(s.readPending),
    .rxByte(rxByte),
    .frameDone(frameDone),
    .frameKind(frameKind),
    .doutOut(doutOut),
    .doutOe_n(doutOe_n)
  );

  always_comb begin
    logic hwReset;
    logic [1:0] en;
    hwReset = 1'b0;
    next_s = s;
    en = {s.chanEn.chan2CmdEnable, s.chanEn.chan1CmdEnable};
    next_s.disconnectPulse = '0;
    next_s.shutdownPulse = 1'b0;
    next_s.rstS1 = rstPin_n;
    next_s.rstS2 = s.rstS1;
    next_s.gciS1 = gciModePin;
    next_s.gciS2 = s.gciS1;
    next_s.clkS1 = pcmClkPresent;
    next_s.clkS2 = s.clkS1;
    if (!s.rstS2) begin
      hwReset = 1'b1;
    end
    if (frameDone && frameKind == slic_cmd_pkg::FR_LONG) begin
      hwReset = 1'b1;
    end
    if (frameDone && frameKind == slic_cmd_pkg::FR_BYTE) begin
      case (s.fsm)
        slic_cmd_pkg::ST_CMD: begin
          next_s.cmd = rxByte;
          if (rxByte[slic_cmd_pkg::RW_BIT]) begin
            if (hasData(rxByte)) begin
              next_s.readByte = readValue(s, rxByte);
              next_s.readPending = 1'b1;
              next_s.fsm = slic_cmd_pkg::ST_RDATA;
            end
          end else if (hasData(rxByte)) begin
            next_s.fsm = slic_cmd_pkg::ST_WDATA;
          end else if (rxByte == slic_cmd_pkg::CMD_SOFT_RESET) begin
            next_s.disconnectPulse = en & ~chanInShutdown;
          end else if (rxByte == slic_cmd_pkg::CMD_HARD_RESET) begin
            hwReset = 1'b1;
          end else if (rxByte == slic_cmd_pkg::CMD_NOP) begin
            next_s.fsm = slic_cmd_pkg::ST_CMD;
          end
        end
        slic_cmd_pkg::ST_WDATA: begin
          next_s.fsm = slic_cmd_pkg::ST_CMD;
          case (s.cmd)
            slic_cmd_pkg::CMD_TX_SLOT: begin
              for (int ch = 0; ch < NUM_CHAN; ch++) begin
                if (en[ch]) begin
                  next_s.txSlot[ch] = rxByte[6:0];
                end
              end
            end
            slic_cmd_pkg::CMD_RX_SLOT: begin
              for (int ch = 0; ch < NUM_CHAN; ch++) begin
                if (en[ch]) begin
                  next_s.rxSlot[ch] = rxByte[6:0];
                end
              end
            end
            slic_cmd_pkg::CMD_CLK_SLOT: begin
              next_s.clkSlot = unpackClkSlot(rxByte);
            end
            slic_cmd_pkg::CMD_DEV_CFG: begin
              next_s.devCfg = unpackDevCfg(rxByte);
            end
            slic_cmd_pkg::CMD_CHAN_EN: begin
              next_s.chanEn = unpackChanEn(rxByte);
            end
            default: next_s.fsm = slic_cmd_pkg::ST_CMD;
          endcase
        end
        slic_cmd_pkg::ST_RDATA: begin
          next_s.readPending = 1'b0;
          next_s.fsm = slic_cmd_pkg::ST_CMD;
        end
        default: next_s.fsm = slic_cmd_pkg::ST_CMD;
      endcase
    end
    if (hwReset) begin
      next_s = hardDefaults(next_s);
      next_s.shutdownPulse = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s <= hardDefaults('{rstS1: 1'b1, rstS2: 1'b1,
        fsm: slic_cmd_pkg::ST_CMD, default: '0});
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    pcmCfg.active = ~s.gciS2;
    pcmCfg.txSlotNum = s.txSlot;
    pcmCfg.rxSlotNum = s.rxSlot;
    pcmCfg.clkSlot = s.clkSlot;
    pcmCfg.highwaySignalingEn = s.devCfg.highwaySignalingEn;
    pcmCfg.pcmClockRateSel = s.devCfg.pcmClockRateSel;
    pcmCfg.pcmClockRateValid =
      s.devCfg.pcmClockRateSel != slic_cmd_pkg::PCM_CLOCK_RATE_SEL_RSV_A &&
      s.devCfg.pcmClockRateSel < slic_cmd_pkg::PCM_CLOCK_RATE_SEL_RSV_MIN;
    if (s.gciS2) begin
      pcmCfg.highwaySignalingEn = 1'b0;
    end
  end

  // Open-drain drives low only; push-pull drives both levels
  assign intOut = s.devCfg.irqOutputStyle ? 1'b0 : ~irqRequest;
  assign intOe_n = s.devCfg.irqOutputStyle ? ~irqRequest : 1'b0;
  assign wideBandwidthSel = s.chanEn.wideBandwidthSel;
  assign chanCmdEnable = {s.chanEn.chan2CmdEnable,
    s.chanEn.chan1CmdEnable};
  assign chanToDisconnect = s.disconnectPulse;
  assign chanToShutdown = s.shutdownPulse;
  assign masterClkSlow = ~s.clkS2;
  assign supervisionRun = s.clkS2 | ~clockSyncStandbyBit;

endmodule : slic_codec_global_command_regs
